// >>> rtl/serwe_pkg.sv
// constants and types shared by the serial eeprom command engine
`default_nettype none
package serwe_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_WR_MS       = 5;
  localparam int unsigned NS_PER_MS     = 1000000;
  // longest time, so integer division rounds down
  localparam int unsigned WR_CYCLES     = T_WR_MS * NS_PER_MS / CLK_PERIOD_NS;
  // power_up_command_delay, kept by the bus master
  localparam int unsigned POWER_UP_COMMAND_DELAY_US      = 100;
  localparam int          BUSY_W        = 21;

  // ---------------------------------------------------------------
  // array geometry and pin widths
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 12;
  localparam int PAGE_W     = 5;
  localparam int BYTE_W     = 8;
  localparam int MEM_DEPTH  = 4096;
  localparam int PAGE_BYTES = 32;
  localparam int HI_BITS    = 4;
  localparam int CS_W       = 3;
  localparam int SYNC_W     = 6;

  // ---------------------------------------------------------------
  // device address byte layout
  // ---------------------------------------------------------------
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int CS_MSB   = 3;
  localparam int CS_LSB   = 1;
  localparam int RW_BIT   = 0;
  // arbitrary value, not tied to any maker
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;

  // ---------------------------------------------------------------
  // bit and commit counter marks
  // ---------------------------------------------------------------
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_MACK = 4'h9;
  localparam logic [5:0] COMMIT_DONE = 6'h20;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WDAT,
    ST_RDAT
  } serwe_state_t;
endpackage : serwe_pkg
`default_nettype wire

// >>> rtl/serwe_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module serwe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule : serwe_sync
`default_nettype wire

// >>> rtl/serwe_engine.sv
// two-wire serial eeprom command engine with 4096-byte array
`default_nettype none
module serwe_engine
  import serwe_pkg::*;
#(
  parameter int unsigned WR_CYCLES_P = WR_CYCLES,
  parameter logic [3:0]  DEV_TYPE    = DEV_TYPE_DEFAULT
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  input  wire logic            wp_in,
  input  wire logic [CS_W-1:0] chip_select_pins,
  output logic                 prog_busy
);
  // ---------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic            scl_s;
  logic            sda_s;
  logic            wp_s;
  logic [CS_W-1:0] cs_s;
  logic            scl_d_reg;
  logic            sda_d_reg;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_det;
  logic            stop_det;

  serwe_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d_in  ({scl_in, sda_in, wp_in, chip_select_pins}),
    .q_out ({scl_s, sda_s, wp_s, cs_s})
  );

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  serwe_state_t            state_reg,     state_next;
  logic [3:0]              bit_reg,       bit_next;
  logic [BYTE_W-1:0]       rx_reg,        rx_next;
  logic [BYTE_W-1:0]       tx_reg,        tx_next;
  logic [ADDR_W-1:0]       addr_reg,      addr_next;
  logic [HI_BITS-1:0]      addr_hi_reg,   addr_hi_next;
  logic                    dev_ack_reg,   dev_ack_next;
  logic                    mack_reg,      mack_next;
  logic                    oe_reg,        oe_next;
  logic                    pend_reg,      pend_next;
  logic [BUSY_W-1:0]       busy_reg,      busy_next;
  logic [5:0]              commit_reg,    commit_next;
  logic [PAGE_BYTES-1:0]   valid_reg,     valid_next;
  logic [BYTE_W-1:0]       pbuf_reg [PAGE_BYTES];
  logic [BYTE_W-1:0]       pbuf_next [PAGE_BYTES];
  logic [BYTE_W-1:0]       mem_reg [MEM_DEPTH];
  logic                    mem_we;
  logic [ADDR_W-1:0]       mem_waddr;
  logic [BYTE_W-1:0]       mem_wdata;
  logic                    do_load;
  logic [PAGE_W-1:0]       commit_idx;

  function automatic logic dev_match(input logic [BYTE_W-1:0] b,
                                     input logic [CS_W-1:0]   cs);
    dev_match = (b[TYPE_MSB:TYPE_LSB] == DEV_TYPE) && (b[CS_MSB:CS_LSB] == cs);
  endfunction : dev_match

  assign commit_idx = commit_reg[PAGE_W-1:0];

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    bit_next     = bit_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    addr_next    = addr_reg;
    addr_hi_next = addr_hi_reg;
    dev_ack_next = dev_ack_reg;
    mack_next    = mack_reg;
    oe_next      = oe_reg;
    pend_next    = pend_reg;
    busy_next    = busy_reg;
    commit_next  = commit_reg;
    valid_next   = valid_reg;
    pbuf_next    = pbuf_reg;
    mem_we       = 1'b0;
    mem_waddr    = {addr_reg[ADDR_W-1:PAGE_W], commit_idx};
    mem_wdata    = pbuf_reg[commit_idx];
    do_load      = 1'b0;

    // page buffer drains into the array one byte per clock
    if (commit_reg != COMMIT_DONE) begin
      mem_we      = valid_reg[commit_idx];
      commit_next = commit_reg + 6'h01;
    end

    if (busy_reg != '0) begin
      // self-timed cycle: deaf and silent on the bus
      busy_next  = busy_reg - {{(BUSY_W-1){1'b0}}, 1'b1};
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (stop_det) begin
      if (state_reg == ST_WDAT && pend_reg && !wp_s) begin
        commit_next = '0;
        busy_next   = BUSY_W'(WR_CYCLES_P - 1);
      end
      state_next   = ST_IDLE;
      oe_next      = 1'b0;
      dev_ack_next = 1'b0;
      pend_next    = 1'b0;
    end else if (start_det) begin
      // abandons any pending write but leaves addr_reg alone
      state_next   = ST_DEV;
      bit_next     = BIT_ZERO;
      oe_next      = 1'b0;
      dev_ack_next = 1'b0;
      pend_next    = 1'b0;
      valid_next   = '0;
    end else if (dev_ack_reg) begin
      // device acknowledge slot ends on the next falling scl
      if (scl_fall) begin
        oe_next      = 1'b0;
        dev_ack_next = 1'b0;
        bit_next     = BIT_ZERO;
        do_load      = (state_reg == ST_RDAT);
      end
    end else begin
      case (state_reg)
        ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
          if (scl_rise && bit_reg < BIT_LAST) begin
            rx_next  = {rx_reg[BYTE_W-2:0], sda_s};
            bit_next = bit_reg + BIT_ONE;
          end else if (scl_fall && bit_reg == BIT_LAST) begin
            dev_ack_next = 1'b1;
            oe_next      = 1'b1;
            case (state_reg)
              ST_DEV: begin
                if (dev_match(rx_reg, cs_s)) begin
                  state_next = rx_reg[RW_BIT] ? ST_RDAT : ST_AHI;
                end else begin
                  state_next   = ST_IDLE;
                  dev_ack_next = 1'b0;
                  oe_next      = 1'b0;
                end
              end
              ST_AHI: begin
                addr_hi_next = rx_reg[HI_BITS-1:0];
                state_next   = ST_ALO;
              end
              ST_ALO: begin
                addr_next  = {addr_hi_reg, rx_reg};
                state_next = ST_WDAT;
              end
              default: begin
                pbuf_next[addr_reg[PAGE_W-1:0]]  = rx_reg;
                valid_next[addr_reg[PAGE_W-1:0]] = 1'b1;
                // upper bits pinned so a long burst wraps in its page
                addr_next = {addr_reg[ADDR_W-1:PAGE_W],
                             addr_reg[PAGE_W-1:0] + 5'h01};
                pend_next = 1'b1;
              end
            endcase
          end
        end
        ST_RDAT: begin
          if (scl_rise && bit_reg < BIT_LAST) begin
            bit_next = bit_reg + BIT_ONE;
          end else if (scl_rise && bit_reg == BIT_LAST) begin
            mack_next = ~sda_s;
            bit_next  = BIT_MACK;
          end else if (scl_fall && bit_reg >= BIT_ONE && bit_reg < BIT_LAST) begin
            tx_next = {tx_reg[BYTE_W-2:0], 1'b1};
            oe_next = ~tx_reg[BYTE_W-2];
          end else if (scl_fall && bit_reg == BIT_LAST) begin
            oe_next = 1'b0;
          end else if (scl_fall && bit_reg == BIT_MACK) begin
            if (mack_reg) begin
              do_load  = 1'b1;
              bit_next = BIT_ZERO;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (do_load) begin
      tx_next   = mem_reg[addr_reg];
      oe_next   = ~mem_reg[addr_reg][BYTE_W-1];
      addr_next = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // power-on reset: nothing is heard until release
      state_reg   <= ST_IDLE;
      bit_reg     <= BIT_ZERO;
      rx_reg      <= '0;
      tx_reg      <= '0;
      addr_reg    <= '0;
      addr_hi_reg <= '0;
      dev_ack_reg <= 1'b0;
      mack_reg    <= 1'b0;
      oe_reg      <= 1'b0;
      pend_reg    <= 1'b0;
      busy_reg    <= '0;
      commit_reg  <= COMMIT_DONE;
      valid_reg   <= '0;
      scl_d_reg   <= 1'b0;
      sda_d_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_reg     <= bit_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      addr_reg    <= addr_next;
      addr_hi_reg <= addr_hi_next;
      dev_ack_reg <= dev_ack_next;
      mack_reg    <= mack_next;
      oe_reg      <= oe_next;
      pend_reg    <= pend_next;
      busy_reg    <= busy_next;
      commit_reg  <= commit_next;
      valid_reg   <= valid_next;
      scl_d_reg   <= scl_s;
      sda_d_reg   <= sda_s;
    end
  end

  // data storage carries no reset: array content survives a bus reset
  always_ff @(posedge ref_clk) begin
    pbuf_reg <= pbuf_next;
    if (mem_we) begin
      mem_reg[mem_waddr] <= mem_wdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sda_out   = 1'b0;
  assign sda_oe    = oe_reg;
  assign prog_busy = (busy_reg != '0);
endmodule : serwe_engine
`default_nettype wire

// >>> tb/serwe_engine_assertions.sv
// pin-level checks for the serial eeprom command engine
`default_nettype none
module serwe_engine_assertions
  import serwe_pkg::*;
#(
  parameter int unsigned WR_CYCLES_P = 1000
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            scl_in,
  input wire logic            sda_in,
  input wire logic            sda_out,
  input wire logic            sda_oe,
  input wire logic            wp_in,
  input wire logic [CS_W-1:0] chip_select_pins,
  input wire logic            prog_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // length of the current busy period, compared when it ends
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;
  always_comb busy_cnt_next = prog_busy ? busy_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) busy_cnt_reg <= rst_n ? busy_cnt_next : 32'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  sequence s_quiet;
    !sda_oe [*8];
  endsequence
  sequence s_prog_go;
    $rose(prog_busy);
  endsequence
  chk_open_drain: assert property (sda_out == 1'h0)
    else $error("data pin driven high");
  chk_busy_mute: assert property (prog_busy |-> !sda_oe)
    else $error("response while programming");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !sda_oe && !prog_busy)
    else $error("activity out of reset");
  // the engine loads one less than the period so the cycle never overruns its maximum
  chk_busy_len: assert property ($fell(prog_busy) |-> busy_cnt_reg == WR_CYCLES_P - 1)
    else $error("programming period length wrong");
  chk_wp_block: assert property (s_prog_go |-> !$past(wp_in, 8))
    else $error("programming while protected");
  chk_prog_on_stop: assert property (s_prog_go |-> $past(scl_in, 2) && $past(sda_in, 2))
    else $error("programming without stop");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("data pin changed while clock high");
  chk_oe_bound: assert property ($rose(sda_oe) |-> ##[1:300] !sda_oe)
    else $error("data pin held low too long");
  chk_stop_quiet: assert property (s_stop |-> s_quiet)
    else $error("drive after stop");
endmodule : serwe_engine_assertions
bind serwe_engine serwe_engine_assertions #(.WR_CYCLES_P(WR_CYCLES_P)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .wp_in(wp_in), .chip_select_pins(chip_select_pins), .prog_busy(prog_busy));
`default_nettype wire

// >>> tb/serwe_mst.sv
// two-wire bus master model, 125 ns clock period
`default_nettype none
module serwe_mst (
  input  wire logic ref_clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w
  // data set mid low phase, sampled mid high phase; clock idles high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    w(6);
    scl = 1'h1;
    w(6);
    r = sda;
    w(7);
    scl = 1'h0;
    w(6);
  endtask : bit_io
  task automatic start;
    sda_low = 1'h0;
    w(6);
    scl = 1'h1;
    w(6);
    sda_low = 1'h1;
    w(6);
    scl = 1'h0;
    w(6);
  endtask : start
  task automatic stop;
    sda_low = 1'h1;
    w(6);
    scl = 1'h1;
    w(6);
    sda_low = 1'h0;
    w(12);
  endtask : stop
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask : wr
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    bit_io(!mack, r);
  endtask : rd
endmodule : serwe_mst
`default_nettype wire

// >>> tb/serwe_engine_bench.sv
// self-checking bench for the serial eeprom command engine
`default_nettype none
module serwe_engine_bench;
  import serwe_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] CS = 3'h5;
  logic       ref_clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       wp_in = 1'h0;
  logic       sda_oe;
  logic       prog_busy;
  logic       scl;
  logic       sda_low;
  logic       a;
  logic [7:0] d;
  int         n_errors = 0;
  int         checks_done = 0;
  // open drain line with pull-up
  wire logic sda_w = !(sda_low | sda_oe);
  serwe_engine #(.WR_CYCLES_P(1000)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .wp_in(wp_in),
    .chip_select_pins(CS), .prog_busy(prog_busy));
  serwe_mst i_mst (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
  always #2.5 ref_clk = ~ref_clk;
  task automatic end_sim;
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [7:0] dv(input logic rw);
    return {DEV_TYPE_DEFAULT, CS, rw};
  endfunction : dv
  task automatic wait_idle;
    for (int n = 0; n < 1200 && prog_busy !== 1'h0; n++) @(negedge ref_clk);
    chk({7'h00, prog_busy}, 8'h00);
    if (prog_busy !== 1'h0) end_sim();
  endtask : wait_idle
  // upper nibble of the high address byte is junk on purpose
  task automatic addr_w(input logic [11:0] ad);
    i_mst.start();
    i_mst.wr(dv(1'h0), a);
    chk({7'h00, a}, 8'h01);
    i_mst.wr({4'hA, ad[11:8]}, a);
    chk({7'h00, a}, 8'h01);
    i_mst.wr(ad[7:0], a);
    chk({7'h00, a}, 8'h01);
  endtask : addr_w
  task automatic rd_setup(input logic [11:0] ad);
    addr_w(ad);
    i_mst.start();
    i_mst.wr(dv(1'h1), a);
    chk({7'h00, a}, 8'h01);
  endtask : rd_setup
  task automatic wpage(input logic [11:0] ad, input logic [7:0] q[$]);
    addr_w(ad);
    foreach (q[i]) begin
      i_mst.wr(q[i], a);
      chk({7'h00, a}, 8'h01);
    end
    i_mst.stop();
  endtask : wpage
  task automatic t_por;
    rst_n = 1'h0;
    i_mst.start();
    i_mst.wr(dv(1'h1), a);
    chk({7'h00, a}, 8'h00);
    i_mst.stop();
    rst_n = 1'h1;
  endtask : t_por
  // 34 bytes from 0x1E of a page: the last two land on the first two
  task automatic t_page;
    logic [7:0] q[$];
    for (int i = 0; i < 34; i++) q.push_back(8'(i * 7 + 3));
    wpage(12'hF3E, q);
    chk({7'h00, prog_busy}, 8'h01);
    i_mst.start();
    i_mst.wr(dv(1'h0), a);
    chk({7'h00, a}, 8'h00);
    i_mst.stop();
    wait_idle();
    rd_setup(12'hF20);
    for (int j = 0; j < 32; j++) begin
      i_mst.rd(j < 31, d);
      chk(d, q[j + 2]);
    end
    i_mst.stop();
  endtask : t_page
  task automatic t_wrap;
    wpage(12'hFFF, '{8'hC3});
    wait_idle();
    wpage(12'h000, '{8'h3C, 8'h96});
    wait_idle();
    rd_setup(12'hFFF);
    i_mst.rd(1'h1, d);
    chk(d, 8'hC3);
    i_mst.rd(1'h0, d);
    chk(d, 8'h3C);
    i_mst.stop();
    i_mst.start();
    i_mst.wr(dv(1'h1), a);
    chk({7'h00, a}, 8'h01);
    i_mst.rd(1'h0, d);
    chk(d, 8'h96);
    i_mst.stop();
  endtask : t_wrap
  task automatic t_wp;
    wp_in = 1'h1;
    wpage(12'h000, '{8'h55});
    chk({7'h00, prog_busy}, 8'h00);
    wp_in = 1'h0;
    rd_setup(12'h000);
    i_mst.rd(1'h0, d);
    chk(d, 8'h3C);
    i_mst.stop();
    addr_w(12'h123);
    i_mst.stop();
    chk({7'h00, prog_busy}, 8'h00);
  endtask : t_wp
  task automatic t_cs;
    for (int k = 0; k < 2; k++) begin
      i_mst.start();
      i_mst.wr(k ? {~DEV_TYPE_DEFAULT, CS, 1'h0} : {DEV_TYPE_DEFAULT, ~CS, 1'h1}, a);
      chk({7'h00, a}, 8'h00);
      i_mst.stop();
    end
  endtask : t_cs
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (POWER_UP_COMMAND_DELAY_US * 1000 / CLK_PERIOD_NS) @(negedge ref_clk);
    t_por();
    t_page();
    t_wrap();
    t_wp();
    t_cs();
    end_sim();
  end
endmodule : serwe_engine_bench
`default_nettype wire
